/* File: rtl/tprs_channel.sv */
// One timer channel: counter, pin levels, initialisation and compare actions.
// Assumes writes and mode come from the register file on the same clock.
`timescale 1ns/100ps
`default_nettype none
module tprs_channel #(
    parameter int chan = 0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [2:0] mode,
    input wire logic buf_c,
    input wire logic buf_d,
    input wire logic cyc_d,
    input wire logic io_write,
    input wire logic [7:0] io_wdata,
    input wire logic out_en,
    input wire logic comp_level,
    input wire logic run,
    input wire logic [15:0] cmp_a,
    input wire logic [15:0] cmp_b,
    output logic [15:0] count,
    output logic [1:0] pin_level
);
    logic [3:0] act_a;
    logic [3:0] act_b;
    logic match_a;
    logic match_b;
    logic comp_mode;
    logic run_q;
    logic init_a;
    logic init_b;

    assign comp_mode = (mode == tprs_pkg::md_complementary) || (mode == tprs_pkg::md_reset_sync);
    assign match_a = run && (count == cmp_a);
    assign match_b = run && (count == cmp_b);

    always_comb begin
        init_a = 1'b1;
        init_b = 1'b1;
        if (mode == tprs_pkg::md_pwm_one) begin
            init_b = 1'b0;
        end else if (mode == tprs_pkg::md_pwm_two) begin
            init_a = cyc_d;
            init_b = !cyc_d;
        end
        if (mode == tprs_pkg::md_normal || mode == tprs_pkg::md_pwm_two) begin
            if (buf_c) begin
                init_a = 1'b0;
            end
            if (buf_d) begin
                init_b = 1'b0;
            end
        end
        if (chan >= 3 && !out_en) begin
            init_a = 1'b0;
            init_b = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= tprs_pkg::counter_reset;
        end else if (run) begin
            count <= count + 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_a <= tprs_pkg::timer_io_control_disabled;
            act_b <= tprs_pkg::timer_io_control_disabled;
            run_q <= 1'b0;
        end else begin
            run_q <= run;
            if (io_write) begin
                act_a <= io_wdata[3:0];
                act_b <= io_wdata[7:4];
            end
        end
    end

    function automatic logic next_on_match(input logic [3:0] act, input logic cur);
        case (act)
            tprs_pkg::timer_io_control_hi_then_lo: next_on_match = 1'b0;
            tprs_pkg::timer_io_control_lo_then_hi: next_on_match = 1'b1;
            tprs_pkg::timer_io_control_hi_toggle, tprs_pkg::timer_io_control_lo_toggle: next_on_match = !cur;
            default: next_on_match = cur;
        endcase
    endfunction : next_on_match

    function automatic logic init_level(input logic [3:0] act, input logic cur);
        case (act)
            tprs_pkg::timer_io_control_hi_then_lo, tprs_pkg::timer_io_control_hi_toggle: init_level = 1'b1;
            tprs_pkg::timer_io_control_lo_then_hi, tprs_pkg::timer_io_control_lo_toggle: init_level = 1'b0;
            default: init_level = cur;
        endcase
    endfunction : init_level

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_level <= 2'b00;
        end else if (comp_mode) begin
            if (!run) begin
                pin_level <= {comp_level, !comp_level};
            end else if (match_a) begin
                pin_level <= ~pin_level;
            end
        end else if (mode == tprs_pkg::md_normal && run_q == 1'b0 && io_write == 1'b0
                     && act_a == tprs_pkg::timer_io_control_disabled && act_b == tprs_pkg::timer_io_control_disabled) begin
            pin_level <= 2'b00;
        end else if (io_write) begin
            // initial level on write, others hold
            pin_level[0] <= init_a ? init_level(io_wdata[3:0], pin_level[0]) : pin_level[0];
            pin_level[1] <= init_b ? init_level(io_wdata[7:4], pin_level[1]) : pin_level[1];
        end else begin
            pin_level[0] <= match_a ? next_on_match(act_a, pin_level[0]) : pin_level[0];
            pin_level[1] <= match_b ? next_on_match(act_b, pin_level[1]) : pin_level[1];
        end
    end
endmodule : tprs_channel
`default_nettype wire

/* File: rtl/tprs_pkg.sv */
// Package for the timer pin recovery sequencer: register map, fields, reset values.
// Assumes a 32-bit APB slave on pclk with one word per register.
package tprs_pkg;
    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [7:0] off_mode_select = 8'h00;
    localparam logic [7:0] off_io_control = 8'h04;
    localparam logic [7:0] off_master_enable = 8'h08;
    localparam logic [7:0] off_level_control = 8'h0c;
    localparam logic [7:0] off_start_control = 8'h10;
    localparam logic [7:0] off_pin_function = 8'h14;
    localparam logic [7:0] off_port_data = 8'h18;
    localparam logic [7:0] off_compare_a = 8'h1c;
    localparam logic [7:0] off_compare_b = 8'h20;
    localparam logic [7:0] off_pin_status = 8'h24;
    localparam logic [7:0] off_counter = 8'h28;
    // ************************************************************
    // Field layout, channels and pins
    // ************************************************************
    localparam int num_chan = 5;
    localparam int num_pin = 10;
    localparam int mode_w = 3;
    localparam int buf_c_bit = 3;
    localparam int buf_d_bit = 4;
    localparam int cyc_d_bit = 5;
    localparam int timer_io_control_w = 4;
    localparam int pin_a_sh = 0;
    localparam int pin_b_sh = 4;
    localparam logic [3:0] timer_io_control_disabled = 4'h0;
    localparam logic [3:0] timer_io_control_hi_then_lo = 4'h5;
    localparam logic [3:0] timer_io_control_lo_then_hi = 4'h6;
    localparam logic [3:0] timer_io_control_hi_toggle = 4'h7;
    localparam logic [3:0] timer_io_control_lo_toggle = 4'h3;
    localparam logic [1:0] master_en_reset = 2'h3;
    localparam logic [1:0] level_reset = 2'h0;
    localparam logic [15:0] counter_reset = 16'h0000;
    localparam logic [15:0] compare_reset = 16'hffff;
    // Mode encodings in mode select
    localparam logic [2:0] md_normal = 3'h0;
    localparam logic [2:0] md_pwm_one = 3'h2;
    localparam logic [2:0] md_pwm_two = 3'h3;
    localparam logic [2:0] md_phase = 3'h4;
    localparam logic [2:0] md_reset_sync = 3'h6;
    localparam logic [2:0] md_complementary = 3'h7;
endpackage : tprs_pkg

/* File: rtl/tprs_top.sv */
// Timer pin recovery sequencer: APB registers, five channels, pin muxing.
// Assumes an APB master on pclk and an external power stage on the pins.
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
module tprs_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [9:0] pin_out,
    output logic [9:0] pin_oe
);
    // ************************************************************
    // Register file
    // ************************************************************
    logic [5:0] mode_reg [tprs_pkg::num_chan];
    logic [7:0] io_reg [tprs_pkg::num_chan];
    logic [1:0] master_en;
    logic [1:0] level_ctl;
    logic [4:0] start_bits;
    logic [9:0] pin_func;
    logic [9:0] port_data;
    logic [15:0] cmp_a [tprs_pkg::num_chan];
    logic [15:0] cmp_b [tprs_pkg::num_chan];
    logic [15:0] count [tprs_pkg::num_chan];
    logic [9:0] levels;
    logic [4:0] io_wr;
    logic [7:0] off;
    logic [2:0] ch;
    logic wr;
    logic [2:0] wmode;
    logic next_slverr;
    logic [31:0] next_prdata;
    logic [4:0] chan_en;

    assign off = paddr[7:0];
    assign ch = paddr[10:8];
    assign wr = psel && penable && pwrite && !pready;
    assign wmode = pwdata[2:0];
    // Channels 0-2 have no master enable, so no index ever goes negative
    assign chan_en = {master_en, 3'b111};

    // One wait state keeps the read mux off the bus path
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
        end
    end

    always_comb begin
        next_slverr = 1'b0;
        if (paddr[31:11] != 21'h000000 || paddr[1:0] != 2'b00) begin
            next_slverr = 1'b1;
        end else if (off == tprs_pkg::off_mode_select || off == tprs_pkg::off_io_control
                     || off == tprs_pkg::off_compare_a || off == tprs_pkg::off_compare_b
                     || off == tprs_pkg::off_counter) begin
            next_slverr = (ch >= 3'(tprs_pkg::num_chan));
        end else if (off == tprs_pkg::off_master_enable || off == tprs_pkg::off_level_control
                     || off == tprs_pkg::off_start_control || off == tprs_pkg::off_pin_function
                     || off == tprs_pkg::off_port_data || off == tprs_pkg::off_pin_status) begin
            next_slverr = (ch != 3'h0);
        end else begin
            next_slverr = 1'b1;
        end
    end

    always_comb begin
        next_prdata = 32'h00000000;
        if (next_slverr) begin
            next_prdata = 32'h00000000;
        end else if (off == tprs_pkg::off_mode_select) begin
            next_prdata = {26'h0000000, mode_reg[ch]};
        end else if (off == tprs_pkg::off_io_control) begin
            next_prdata = {24'h000000, io_reg[ch]};
        end else if (off == tprs_pkg::off_master_enable) begin
            next_prdata = {30'h00000000, master_en};
        end else if (off == tprs_pkg::off_level_control) begin
            next_prdata = {30'h00000000, level_ctl};
        end else if (off == tprs_pkg::off_start_control) begin
            next_prdata = {27'h0000000, start_bits};
        end else if (off == tprs_pkg::off_pin_function) begin
            next_prdata = {22'h000000, pin_func};
        end else if (off == tprs_pkg::off_port_data) begin
            next_prdata = {22'h000000, port_data};
        end else if (off == tprs_pkg::off_compare_a) begin
            next_prdata = {16'h0000, cmp_a[ch]};
        end else if (off == tprs_pkg::off_compare_b) begin
            next_prdata = {16'h0000, cmp_b[ch]};
        end else if (off == tprs_pkg::off_pin_status) begin
            next_prdata = {22'h000000, levels};
        end else if (off == tprs_pkg::off_counter) begin
            next_prdata = {16'h0000, count[ch]};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            prdata <= (psel && penable && !pready && !pwrite) ? next_prdata : 32'h00000000;
            pslverr <= psel && penable && !pready && next_slverr;
        end
    end

    // ************************************************************
    // Register writes
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < tprs_pkg::num_chan; i++) begin
                mode_reg[i] <= {3'h0, tprs_pkg::md_normal};
                io_reg[i] <= 8'h00;
                cmp_a[i] <= tprs_pkg::compare_reset;
                cmp_b[i] <= tprs_pkg::compare_reset;
            end
        end else if (wr && !next_slverr) begin
            if (off == tprs_pkg::off_mode_select) begin
                if (wmode == tprs_pkg::md_pwm_two && ch > 3'h2) begin
                    mode_reg[ch] <= {pwdata[5:3], mode_reg[ch][2:0]};
                end else if (wmode == tprs_pkg::md_phase && (ch < 3'h1 || ch > 3'h2)) begin
                    mode_reg[ch] <= {pwdata[5:3], mode_reg[ch][2:0]};
                end else begin
                    mode_reg[ch] <= pwdata[5:0];
                end
            end else if (off == tprs_pkg::off_io_control) begin
                io_reg[ch] <= pwdata[7:0];
            end else if (off == tprs_pkg::off_compare_a) begin
                cmp_a[ch] <= pwdata[15:0];
            end else if (off == tprs_pkg::off_compare_b) begin
                cmp_b[ch] <= pwdata[15:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            master_en <= tprs_pkg::master_en_reset;
            level_ctl <= tprs_pkg::level_reset;
            start_bits <= 5'h00;
            pin_func <= 10'h000;
            port_data <= 10'h000;
        end else if (wr && !next_slverr) begin
            if (off == tprs_pkg::off_master_enable) begin
                master_en <= pwdata[1:0];
            end else if (off == tprs_pkg::off_level_control) begin
                level_ctl <= pwdata[1:0];
            end else if (off == tprs_pkg::off_start_control) begin
                start_bits <= pwdata[4:0];
            end else if (off == tprs_pkg::off_pin_function) begin
                pin_func <= pwdata[9:0];
            end else if (off == tprs_pkg::off_port_data) begin
                port_data <= pwdata[9:0];
            end
        end
    end

    always_comb begin
        io_wr = 5'h00;
        if (wr && !next_slverr && off == tprs_pkg::off_io_control) begin
            io_wr[ch] = 1'b1;
        end
    end

    // ************************************************************
    // Channels
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < tprs_pkg::num_chan; g++) begin : gen_chan
            tprs_channel #(.chan(g)) u_chan (
                .pclk(pclk),
                .presetn(presetn),
                .mode(mode_reg[g][2:0]),
                .buf_c(mode_reg[g][tprs_pkg::buf_c_bit]),
                .buf_d(mode_reg[g][tprs_pkg::buf_d_bit]),
                .cyc_d(mode_reg[g][tprs_pkg::cyc_d_bit]),
                .io_write(io_wr[g]),
                .io_wdata(pwdata[7:0]),
                .out_en(chan_en[g]),
                .comp_level(level_ctl[0]),
                .run(start_bits[g]),
                .cmp_a(cmp_a[g]),
                .cmp_b(cmp_b[g]),
                .count(count[g]),
                .pin_level(levels[2*g+1:2*g])
            );
        end
    endgenerate

    // ************************************************************
    // Pin function mux
    // ************************************************************
    // pins high-Z until assigned
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out <= 10'h000;
            pin_oe <= 10'h000;
        end else begin
            for (int p = 0; p < tprs_pkg::num_pin; p++) begin
                pin_oe[p] <= pin_func[p] ? chan_en[p/2] : port_data[p];
                pin_out[p] <= pin_func[p] ? levels[p] : port_data[p];
            end
        end
    end
endmodule : tprs_top
`default_nettype wire

/* File: tb/tb_timer_pin_recovery_sequencer.sv */
// Testbench for the timer pin recovery sequencer: recovery sequences over APB.
// Assumes tprs_top, its checker bind and the power stage model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb_timer_pin_recovery_sequencer;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [9:0] pin_out;
    logic [9:0] pin_oe;
    logic [9:0] gate_n;
    logic [31:0] rd;
    logic [31:0] c1;
    logic er;
    int mismatches = 0;
    int cmp_count = 0;
    logic [31:0] bad[5] = '{32'h02c, 32'h002, 32'h800, 32'h108, 32'h500};
    logic [2:0] mw[4] = '{3'h3, 3'h4, 3'h4, 3'h4};
    logic [2:0] me[4] = '{3'h0, 3'h0, 3'h2, 3'h4};
    int mc[4] = '{3, 4, 0, 1};
    always #4 pclk = ~pclk;
    tprs_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_out(pin_out), .pin_oe(pin_oe));
    tprs_power_stage stage_u (.pin_out(pin_out), .pin_oe(pin_oe), .gate_n(gate_n));

    function automatic logic [31:0] ra(input int ch, input logic [7:0] off);
        return (32'(ch) << 8) | {24'h0, off};
    endfunction : ra

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // ************************************************************
    // APB master: setup, access held until pready
    // ************************************************************
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        check({31'h0, pready}, 32'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic pin_is(input int i, input logic v);
        int n;
        n = 0;
        #1;
        while (pin_out[i] !== v && n < 40) begin
            @(posedge pclk);
            #1;
            n++;
        end
        check({31'h0, pin_out[i]}, {31'h0, v});
    endtask : pin_is

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run

    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        complete_run();
    end

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        check({22'h0, pin_oe, pin_out}, 32'h0);
        apb(1'b0, ra(0, tprs_pkg::off_master_enable), 32'h0);
        check(rd, {30'h0, tprs_pkg::master_en_reset});
        apb(1'b0, ra(0, tprs_pkg::off_level_control), 32'h0);
        check(rd, {30'h0, tprs_pkg::level_reset});
        apb(1'b0, ra(0, tprs_pkg::off_start_control), 32'h0);
        check(rd, 32'h0);
        apb(1'b0, ra(1, tprs_pkg::off_counter), 32'h0);
        check(rd, {16'h0, tprs_pkg::counter_reset});
        $display("Test reset values done");
        for (int k = 0; k < 5; k++) begin
            apb(1'b1, bad[k], 32'hffffffff);
            check({31'h0, er}, 32'h1);
            apb(1'b0, bad[k], 32'h0);
            check({er, rd[30:0]}, 32'h80000000);
        end
        $display("Test refused accesses done");
        apb(1'b1, ra(0, tprs_pkg::off_pin_function), 32'h3ff);
        #1;
        check({22'h0, pin_oe}, 32'h3ff);
        apb(1'b1, ra(0, tprs_pkg::off_mode_select), {29'h0, tprs_pkg::md_pwm_one});
        apb(1'b1, ra(0, tprs_pkg::off_io_control), 32'h55);
        pin_is(0, 1'b1);
        apb(1'b1, ra(0, tprs_pkg::off_io_control), 32'h55);
        pin_is(1, 1'b0);
        $display("Test pwm one initialisation done");
        apb(1'b1, ra(1, tprs_pkg::off_io_control), {28'h0, tprs_pkg::timer_io_control_hi_then_lo});
        apb(1'b1, ra(1, tprs_pkg::off_compare_a), 32'h10);
        pin_is(2, 1'b1);
        apb(1'b1, ra(0, tprs_pkg::off_start_control), 32'h2);
        pin_is(2, 1'b0);
        apb(1'b1, ra(0, tprs_pkg::off_port_data), 32'h3ff);
        apb(1'b1, ra(0, tprs_pkg::off_pin_function), 32'h0);
        pin_is(2, 1'b1);
        check({22'h0, gate_n}, 32'h3ff);
        apb(1'b1, ra(0, tprs_pkg::off_start_control), 32'h0);
        apb(1'b0, ra(1, tprs_pkg::off_counter), 32'h0);
        c1 = rd;
        apb(1'b0, ra(1, tprs_pkg::off_counter), 32'h0);
        check(rd, c1);
        apb(1'b1, ra(0, tprs_pkg::off_pin_function), 32'h3ff);
        apb(1'b1, ra(0, tprs_pkg::off_start_control), 32'h2);
        apb(1'b0, ra(1, tprs_pkg::off_counter), 32'h0);
        check({31'h0, rd != c1}, 32'h1);
        $display("Test normal error recovery done");
        apb(1'b1, ra(2, tprs_pkg::off_mode_select), {29'h0, tprs_pkg::md_pwm_two});
        apb(1'b1, ra(2, tprs_pkg::off_io_control), 32'h55);
        pin_is(5, 1'b1);
        pin_is(4, 1'b0);
        $display("Test pwm two initialisation done");
        apb(1'b1, ra(2, tprs_pkg::off_mode_select), {29'h0, tprs_pkg::md_normal});
        apb(1'b1, ra(2, tprs_pkg::off_io_control), 32'h55);
        pin_is(4, 1'b1);
        $display("Test pwm two to normal done");
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, ra(mc[k], tprs_pkg::off_mode_select), {29'h0, mw[k]});
            apb(1'b0, ra(mc[k], tprs_pkg::off_mode_select), 32'h0);
            check({29'h0, rd[2:0]}, {29'h0, me[k]});
        end
        $display("Test mode legality done");
        apb(1'b1, ra(0, tprs_pkg::off_mode_select), 32'h8);
        apb(1'b1, ra(0, tprs_pkg::off_io_control), 32'h56);
        pin_is(1, 1'b1);
        pin_is(0, 1'b1);
        $display("Test buffer pins done");
        apb(1'b1, ra(0, tprs_pkg::off_master_enable), 32'h3);
        apb(1'b1, ra(3, tprs_pkg::off_io_control), 32'h55);
        pin_is(6, 1'b1);
        apb(1'b1, ra(3, tprs_pkg::off_io_control), 32'h0);
        apb(1'b1, ra(0, tprs_pkg::off_master_enable), 32'h0);
        #1;
        check({22'h0, pin_oe}, 32'h03f);
        apb(1'b1, ra(0, tprs_pkg::off_level_control), 32'h0);
        apb(1'b1, ra(3, tprs_pkg::off_mode_select), {29'h0, tprs_pkg::md_complementary});
        apb(1'b1, ra(0, tprs_pkg::off_master_enable), 32'h3);
        pin_is(7, 1'b0);
        pin_is(6, 1'b1);
        apb(1'b1, ra(3, tprs_pkg::off_mode_select), {29'h0, tprs_pkg::md_normal});
        pin_is(6, 1'b0);
        pin_is(7, 1'b0);
        $display("Test complementary recovery done");
        apb(1'b1, ra(0, tprs_pkg::off_master_enable), 32'h0);
        apb(1'b1, ra(0, tprs_pkg::off_level_control), 32'h0);
        apb(1'b1, ra(4, tprs_pkg::off_mode_select), {29'h0, tprs_pkg::md_reset_sync});
        apb(1'b1, ra(0, tprs_pkg::off_master_enable), 32'h3);
        pin_is(8, 1'b1);
        pin_is(9, 1'b0);
        $display("Test reset-sync recovery done");
        complete_run();
    end
endmodule : tb_timer_pin_recovery_sequencer
`default_nettype wire

/* File: tb/tprs_power_stage.sv */
// Model of the external power stage fed by the timer pins, gate inputs active low.
// Assumes pull-ups on the gate lines, so a released pin means stage off.
`timescale 1ns/100ps
`default_nettype none
module tprs_power_stage (
    input wire logic [9:0] pin_out,
    input wire logic [9:0] pin_oe,
    output logic [9:0] gate_n
);
    assign gate_n = (pin_out & pin_oe) | ~pin_oe;
endmodule : tprs_power_stage
`default_nettype wire

/* File: tb/tprs_props.sv */
// Checker for the timer pin recovery sequencer: APB timing, refusals, pin reset.
// Bound to tprs_top below; sees that module's ports only.
`timescale 1ns/100ps
`default_nettype none
module tprs_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [9:0] pin_out,
    input wire logic [9:0] pin_oe
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc;
    logic [2:0] since_wr;
    assign acc = psel && penable;
    // Saturating age of the last write, so enables can only follow software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            since_wr <= 3'h7;
        end else if (acc && pwrite) begin
            since_wr <= 3'h0;
        end else if (since_wr != 3'h7) begin
            since_wr <= since_wr + 3'h1;
        end
    end
    a_reset_quiet: assert property (!$past(presetn) |-> pin_out == 10'h000 && pin_oe == 10'h000)
        else $error("pins not quiet after reset");
    a_oe_by_write: assert property ($changed(pin_oe) |-> since_wr <= 3'h4)
        else $error("pin enable changed without a write");
    a_ready_wait: assert property (acc && !pready |=> pready)
        else $error("pready not one cycle after access");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_ready_cause: assert property (pready |-> $past(acc))
        else $error("pready without access");
    a_err_rdata: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error response malformed");
    a_unmapped_err: assert property (acc && !pready && paddr[7:0] == 8'h2c |=> pslverr)
        else $error("unmapped offset accepted");
    a_unaligned_err: assert property (acc && !pready && paddr[1:0] != 2'h0 |=> pslverr)
        else $error("unaligned address accepted");
    a_high_addr: assert property (acc && !pready && paddr >= 32'h800 |=> pslverr)
        else $error("address above map accepted");
    cover property (pready && pslverr);
    cover property (pready && !pwrite && !pslverr);
    cover property ($changed(pin_out));
endmodule : tprs_props
bind tprs_top tprs_props chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_out(pin_out), .pin_oe(pin_oe));
`default_nettype wire
